// >>> design/dav_group.sv
`timescale 1ns/1ps
`default_nettype none
module dav_group
   import dav_pkg::*;
#(
   parameter int W        = 16,
   parameter int DEPTH_P  = 256,
   parameter bit HAS_PEAK = 1'b1
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rstn,
   // settings and events
   input  wire dav_gcfg_t    cfg,
   input  wire logic         start_pulse,
   input  wire logic         clr_pulse,
   // samples
   input  wire logic         smp_valid,
   input  wire logic [W-1:0] smp,
   // results
   output logic [W-1:0]      avg,
   output logic [W-1:0]      peak
);
   localparam int AW = $clog2(DEPTH_P);
   localparam int SW = W + 16;

   logic [W-1:0]  hist [DEPTH_P];
   logic [AW-1:0] wp;
   logic [SW-1:0] sum, nsum, x, rnum, quo;
   logic [15:0]   cnt, ecnt, ival, wlen, len, rden, den;
   logic [16:0]   rem, trial;
   logic [17:0]   mode, mode_q;
   logic [5:0]    bitc;
   logic          full, req, restart;
   dav_div_t      st;

   //------------------------------------------------------------
   // window length and sliding sum
   //------------------------------------------------------------
   always_comb begin
      wlen = cfg.by_edge ? ival : cfg.duration;            // RL3 RL4
      if (wlen == 16'h0000) len = 16'h0001;
      else if (wlen > 16'(DEPTH_P)) len = 16'(DEPTH_P);
      else len = wlen;
      full    = cnt >= len;
      x       = SW'(smp);
      nsum    = sum + x - (full ? SW'(hist[wp - len[AW-1:0]]) : '0);
      // a fixed edge period follows the edges, so a new interval must not wipe its first sample
      mode    = {cfg.fixed, cfg.by_edge, (cfg.fixed && cfg.by_edge) ? 16'h0000 : len};
      restart = mode != mode_q;
   end

   // sample history, no reset needed
   always_ff @(posedge clk) begin
      if (smp_valid) hist[wp] <= smp;
   end

   // window type change, or window length change outside fixed edge mode, restarts accumulation
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) mode_q <= '0;
      else mode_q <= mode;
   end

   // interval between start edges
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ecnt <= '0;
         ival <= '0;
      end else if (clr_pulse) begin
         ecnt <= '0;
         ival <= '0;
      end else if (start_pulse) begin
         ival <= ecnt;                                       // RL4
         ecnt <= {15'h0000, smp_valid};
      end else if (smp_valid && ecnt != CNT_MAX) begin
         ecnt <= ecnt + 16'h0001;
      end
   end

   //------------------------------------------------------------
   // accumulation per window type
   //------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sum <= '0; cnt <= '0; wp <= '0;
         req <= 1'b0; rnum <= '0; rden <= '0;
      end else if (clr_pulse || restart) begin
         sum <= '0; cnt <= '0; req <= 1'b0;                  // RL5
      end else begin
         req <= 1'b0;
         if (smp_valid) wp <= wp + 1'b1;
         if (!cfg.fixed) begin
            if (smp_valid) begin                             // RL1
               sum  <= nsum;
               cnt  <= full ? cnt : cnt + 16'h0001;
               rnum <= nsum;
               rden <= full ? len : cnt + 16'h0001;
               req  <= !(cfg.by_edge && ival == 16'h0000);
            end
         end else if (cfg.by_edge) begin
            if (start_pulse) begin                           // RL4 RL2
               req  <= cnt != 16'h0000;
               rnum <= sum;
               rden <= cnt;
               sum  <= smp_valid ? x : '0;
               cnt  <= {15'h0000, smp_valid};
            end else if (smp_valid && cnt != CNT_MAX) begin
               sum <= sum + x;
               cnt <= cnt + 16'h0001;
            end
         end else if (smp_valid) begin
            if (cnt + 16'h0001 >= len) begin                 // RL3 RL2
               req  <= 1'b1;
               rnum <= sum + x;
               rden <= cnt + 16'h0001;
               sum  <= '0;
               cnt  <= '0;
            end else begin
               sum <= sum + x;
               cnt <= cnt + 16'h0001;
            end
         end
      end
   end

   //------------------------------------------------------------
   // serial restoring divider, one quotient bit per clock
   //------------------------------------------------------------
   always_comb trial = {rem[15:0], quo[SW-1]};

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st <= DIV_IDLE; quo <= '0; rem <= '0; den <= '0; bitc <= '0;
      end else if (clr_pulse) begin
         st <= DIV_IDLE;
      end else begin
         case (st)
            DIV_IDLE: if (req) begin
               quo  <= rnum;
               rem  <= '0;
               den  <= rden;
               bitc <= 6'(SW - 1);
               st   <= DIV_RUN;
            end
            DIV_RUN: begin
               if (trial >= {1'b0, den}) begin
                  rem <= trial - {1'b0, den};
                  quo <= {quo[SW-2:0], 1'b1};
               end else begin
                  rem <= trial;
                  quo <= {quo[SW-2:0], 1'b0};
               end
               if (bitc == 6'd0) st <= DIV_DONE;
               else bitc <= bitc - 6'd1;
            end
            DIV_DONE: st <= DIV_IDLE;
            default:  st <= DIV_IDLE;
         endcase
      end
   end

   // results and peak tracking
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         avg  <= '0;
         peak <= '0;
      end else if (clr_pulse) begin
         avg  <= '0;                                         // RL5 RL7 RL8 RL9
         peak <= '0;
      end else if (st == DIV_DONE) begin
         avg <= quo[W-1:0];
         if (HAS_PEAK && quo[W-1:0] > peak) peak <= quo[W-1:0];   // RL10
      end
   end
endmodule : dav_group
`default_nettype wire

// >>> design/dav_pkg.sv
//------------------------------------------------------------
// Contract
// (RL1) A sliding group averages continuously over a window that moves with time.
// (RL2) A fixed group clears its accumulation at each period end and starts anew.
// (RL3) In duration mode the period length is the group's duration setting. The code limits it to 1 to DEPTH_P samples.
// (RL4) In edge mode a period is the span between two rising start-signal edges.
// (RL5) A direct reset command clears all average and peak values of the group.
// (RL6) An assigned reset signal clears the group on its rising edge only.
// (RL7) The current group keeps peaks and its reset clears averages and peaks.
// (RL8) The power group keeps peaks and its reset clears averages and peaks.
// (RL9) The voltage group has its own settings and its reset clears its average.
// (RL10) A peak holds the largest average since reset and rises with a larger one.
// (RL11) Minimum and maximum statistics clear on rising edges of their own signals.
//------------------------------------------------------------
package dav_pkg;
   localparam int NGRP = 3;
   localparam int SMPW = 16;
   localparam int SELW = 3;
   localparam int NBIN = 1 << SELW;
   localparam int DEPTH = 256;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL0  = 8'h00;   // +4 per group
   localparam logic [7:0] OFS_CMD    = 8'h0c;
   localparam logic [7:0] OFS_MMSEL  = 8'h10;
   localparam logic [7:0] OFS_AVG0   = 8'h20;
   localparam logic [7:0] OFS_PEAK0  = 8'h30;
   localparam logic [7:0] OFS_MIN0   = 8'h40;
   localparam logic [7:0] OFS_MAX0   = 8'h50;

   // control word field positions
   localparam int CTL_FIXED = 0;
   localparam int CTL_EDGE  = 1;
   localparam int CTL_START = 4;
   localparam int CTL_RESET = 8;
   localparam int CTL_DUR   = 16;
   localparam int MM_MIN    = 0;
   localparam int MM_MAX    = 4;

   // values after reset, and the count limit
   localparam logic [15:0] DUR_RST  = 16'h0010;
   localparam logic [15:0] MIN_RST  = 16'hffff;
   localparam logic [15:0] CNT_MAX  = 16'hffff;

   typedef struct packed {
      logic        valid;
      logic [15:0] cur;
      logic [15:0] volt;
      logic [15:0] pwr;
   } dav_sample_t;

   typedef struct packed {
      logic [15:0]     duration;
      logic [SELW-1:0] reset_sel;
      logic [SELW-1:0] start_sel;
      logic            by_edge;
      logic            fixed;
   } dav_gcfg_t;

   typedef enum logic [1:0] {
      DIV_IDLE = 2'b00,
      DIV_RUN  = 2'b01,
      DIV_DONE = 2'b11
   } dav_div_t;
endpackage : dav_pkg

// >>> design/dav_top.sv
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dav_top
   import dav_pkg::*;
#(
   parameter int DEPTH_P = DEPTH
) (
   // clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // apb slave
   input  wire logic [7:0]        paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // measurement samples, same clock
   input  wire dav_sample_t       smp,
   // assignable binary signals, asynchronous
   input  wire logic [NBIN-1:0]   bin_in
);
   dav_gcfg_t       cfg_reg [NGRP];
   logic [SELW-1:0] min_sel_reg, max_sel_reg;
   logic [NBIN-1:0] bin_s1, bin_s2, bin_s3, rise;
   logic [NGRP-1:0] cmd_clr, clr_reg, start_pls;
   logic [15:0]     gsmp [NGRP];
   logic [15:0]     avg  [NGRP];
   logic [15:0]     peak [NGRP];
   logic [15:0]     min_reg [NGRP];
   logic [15:0]     max_reg [NGRP];
   logic            setup, access, wr_en;
   logic [31:0]     rd_next;
   logic            err_next;

   //------------------------------------------------------------
   // helpers
   //------------------------------------------------------------
   // pick one assignable binary edge
   function automatic logic pick(input logic [NBIN-1:0] v,
                                 input logic [SELW-1:0] s);
      pick = v[s];
   endfunction : pick

   // control register image
   function automatic logic [31:0] cfg_word(input dav_gcfg_t c);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[CTL_FIXED]               = c.fixed;
      w[CTL_EDGE]                = c.by_edge;
      w[CTL_START +: SELW]       = c.start_sel;
      w[CTL_RESET +: SELW]       = c.reset_sel;
      w[CTL_DUR +: 16]           = c.duration;
      cfg_word = w;
   endfunction : cfg_word

   // register index inside a three-word bank, 3 when outside or at the fourth word
   function automatic logic [1:0] bank(input logic [7:0] a,
                                       input logic [7:0] base);
      if (a[7:4] == base[7:4] && a[1:0] == 2'b00 && a[3:2] != 2'b11)
         bank = a[3:2];
      else
         bank = 2'b11;
   endfunction : bank

   //------------------------------------------------------------
   // binary input synchroniser and edge detect
   //------------------------------------------------------------
   // two flops, then a third stage for the edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bin_s1 <= '0;
         bin_s2 <= '0;
         bin_s3 <= '0;
      end else begin
         bin_s1 <= bin_in;
         bin_s2 <= bin_s1;
         bin_s3 <= bin_s2;
      end
   end

   assign rise = bin_s2 & ~bin_s3;                          // RL6 RL11

   //------------------------------------------------------------
   // apb access phases
   //------------------------------------------------------------
   assign setup  = psel && !penable;
   assign access = psel && penable && pready;
   assign wr_en  = access && pwrite && !pslverr;

   // slave answers with zero wait states from the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) pready <= 1'b0;
      else pready <= 1'b1;
   end

   // read data and error latched in the setup cycle
   always_comb begin
      rd_next  = 32'h0000_0000;
      err_next = 1'b0;
      if (bank(paddr, OFS_CTRL0) != 2'b11)
         rd_next = cfg_word(cfg_reg[bank(paddr, OFS_CTRL0)]);
      else if (paddr == OFS_CMD)
         rd_next = 32'h0000_0000;                            // write-only pulses
      else if (paddr == OFS_MMSEL) begin
         rd_next[MM_MIN +: SELW] = min_sel_reg;
         rd_next[MM_MAX +: SELW] = max_sel_reg;
      end else if (bank(paddr, OFS_AVG0) != 2'b11)
         rd_next[15:0] = avg[bank(paddr, OFS_AVG0)];
      else if (bank(paddr, OFS_PEAK0) != 2'b11)
         rd_next[15:0] = peak[bank(paddr, OFS_PEAK0)];
      else if (bank(paddr, OFS_MIN0) != 2'b11)
         rd_next[15:0] = min_reg[bank(paddr, OFS_MIN0)];
      else if (bank(paddr, OFS_MAX0) != 2'b11)
         rd_next[15:0] = max_reg[bank(paddr, OFS_MAX0)];
      else
         err_next = 1'b1;                                    // unmapped
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (setup) begin
         prdata  <= pwrite ? 32'h0000_0000 : rd_next;
         pslverr <= err_next;
      end else if (!psel) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
   end

   //------------------------------------------------------------
   // configuration registers
   //------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int g = 0; g < NGRP; g++) begin
            cfg_reg[g]          <= '0;
            cfg_reg[g].duration <= DUR_RST;
         end
         min_sel_reg <= '0;
         max_sel_reg <= '0;
      end else if (wr_en) begin
         if (bank(paddr, OFS_CTRL0) != 2'b11) begin          // RL9
            cfg_reg[bank(paddr, OFS_CTRL0)].fixed     <= pwdata[CTL_FIXED];
            cfg_reg[bank(paddr, OFS_CTRL0)].by_edge   <= pwdata[CTL_EDGE];
            cfg_reg[bank(paddr, OFS_CTRL0)].start_sel <= pwdata[CTL_START +: SELW];
            cfg_reg[bank(paddr, OFS_CTRL0)].reset_sel <= pwdata[CTL_RESET +: SELW];
            cfg_reg[bank(paddr, OFS_CTRL0)].duration  <= pwdata[CTL_DUR +: 16];
         end
         if (paddr == OFS_MMSEL) begin
            min_sel_reg <= pwdata[MM_MIN +: SELW];
            max_sel_reg <= pwdata[MM_MAX +: SELW];
         end
      end
   end

   // direct reset command, one bit per group
   assign cmd_clr = (wr_en && paddr == OFS_CMD) ? pwdata[NGRP-1:0] : '0;

   //------------------------------------------------------------
   // per-group sample routing, clears and min/max
   //------------------------------------------------------------
   assign gsmp[0] = smp.cur;
   assign gsmp[1] = smp.volt;
   assign gsmp[2] = smp.pwr;

   generate
      for (genvar g = 0; g < NGRP; g++) begin : grp
         assign start_pls[g] = pick(rise, cfg_reg[g].start_sel);   // RL4

         // command or reset-signal edge, held one cycle
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) clr_reg[g] <= 1'b0;
            else clr_reg[g] <= cmd_clr[g] | pick(rise, cfg_reg[g].reset_sel); // RL5 RL6
         end

         // minimum and maximum of raw samples
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               min_reg[g] <= MIN_RST;
               max_reg[g] <= '0;
            end else begin
               if (pick(rise, min_sel_reg)) min_reg[g] <= MIN_RST;      // RL11
               else if (smp.valid && gsmp[g] < min_reg[g]) min_reg[g] <= gsmp[g];
               if (pick(rise, max_sel_reg)) max_reg[g] <= '0;           // RL11
               else if (smp.valid && gsmp[g] > max_reg[g]) max_reg[g] <= gsmp[g];
            end
         end

         // averaging engine; voltage keeps no peak
         dav_group #(
            .W        (SMPW),
            .DEPTH_P  (DEPTH_P),
            .HAS_PEAK (g != 1)                                          // RL7 RL8
         ) u_grp (
            .clk         (pclk),
            .rstn        (presetn),
            .cfg         (cfg_reg[g]),
            .start_pulse (start_pls[g]),
            .clr_pulse   (clr_reg[g]),
            .smp_valid   (smp.valid),
            .smp         (gsmp[g]),
            .avg         (avg[g]),
            .peak        (peak[g])
         );
      end
   endgenerate
endmodule : dav_top
`default_nettype wire

// >>> verification/dav_checker.sv
`timescale 1ns/1ps
`default_nettype none
//----------------------------------------
// apb port checker
//----------------------------------------
module dav_checker
   import dav_pkg::*;
(
   // clock and reset
   input wire logic            pclk,
   input wire logic            presetn,
   // apb
   input wire logic [7:0]      paddr,
   input wire logic            psel,
   input wire logic            penable,
   input wire logic            pwrite,
   input wire logic [31:0]     pwdata,
   input wire logic [31:0]     prdata,
   input wire logic            pready,
   input wire logic            pslverr,
   // samples and pins
   input wire dav_sample_t     smp,
   input wire logic [NBIN-1:0] bin_in
);
   logic acc;
   logic rdq;
   logic mapped;
   // access phase decode and address map
   assign acc = psel && penable;
   assign rdq = acc && !pwrite;
   assign mapped = paddr[1:0] == 2'b00 && (paddr <= OFS_MMSEL ||
      (paddr[7:4] inside {4'h2, 4'h3, 4'h4, 4'h5} && paddr[3:0] <= 4'h8));
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ready_high_a: assert property ($past(presetn) |-> pready)
      else $error("pready low after reset");
   unmapped_err_a: assert property (acc && !mapped |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   mapped_ok_a: assert property (acc && mapped |-> !pslverr)
      else $error("mapped access refused");
   write_quiet_a: assert property (acc && pwrite |-> prdata == 32'h0)
      else $error("read data during write");
   cmd_read_a: assert property (rdq && paddr == OFS_CMD |-> prdata == 32'h0)
      else $error("command register not write-only");
   vpeak_zero_a: assert property (rdq && paddr == OFS_PEAK0 + 8'h04 |-> prdata == 32'h0)
      else $error("voltage group shows a peak");
   upper_zero_a: assert property (rdq && paddr >= OFS_AVG0 |-> prdata[31:16] == 16'h0)
      else $error("result wider than 16 bits");
   idle_quiet_a: assert property (!psel && $past(psel) == 1'b0 |-> !pslverr && prdata == 32'h0)
      else $error("outputs not quiet when idle");
   // main scenarios
   cover property (acc && pwrite && paddr == OFS_CMD);
   cover property (acc && !mapped);
   cover property (smp.valid ##[1:60] rdq && paddr == OFS_AVG0);
endmodule : dav_checker

bind dav_top dav_checker u_dav_checker (.pclk(pclk), .presetn(presetn), .paddr(paddr),
   .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .smp(smp), .bin_in(bin_in));
`default_nettype wire

// >>> verification/dav_src_model.sv
`timescale 1ns/1ps
`default_nettype none
//----------------------------------------
// measurement source and binary pins
//----------------------------------------
module dav_src_model
   import dav_pkg::*;
(
   // clock
   input  wire logic            pclk,
   // bench commands
   input  wire logic            go,
   input  wire logic [47:0]     vals,
   input  wire logic [NBIN-1:0] lvl,
   // to the block
   output dav_sample_t          smp,
   output logic [NBIN-1:0]      bin_in
);
   initial smp = '0;
   initial bin_in = '0;
   // one-cycle sample pulse; data toggles when not valid
   always @(posedge pclk) begin
      smp.valid <= go;
      if (go) begin
         {smp.cur, smp.volt, smp.pwr} <= vals;
      end else begin
         {smp.cur, smp.volt, smp.pwr} <= ~{smp.cur, smp.volt, smp.pwr};
      end
   end
   // pins move off the clock edge, 3 ns after the edge that changes lvl
   always @(lvl) bin_in <= #3 lvl;
endmodule : dav_src_model
`default_nettype wire

// >>> verification/tb_demand_average_calculator.sv
`timescale 1ns/1ps
`default_nettype none
//----------------------------------------
// bench top
//----------------------------------------
module tb_demand_average_calculator;
   import dav_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic [7:0]  paddr = '0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        go = 1'b0;
   logic [47:0] vals = '0;
   logic [7:0]  lvl = '0;
   logic [7:0]  bin_in;
   dav_sample_t smp;
   int          err_total = 0;
   int          n_tests = 0;
   logic [31:0] rd;
   logic        er;

   // 50 mhz clock
   always #10 pclk = ~pclk;

   dav_top #(.DEPTH_P(16)) u_dav_top (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .smp(smp), .bin_in(bin_in));
   dav_src_model u_dav_src_model (.pclk(pclk), .go(go), .vals(vals), .lvl(lvl),
      .smp(smp), .bin_in(bin_in));

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // one apb transfer, held until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, rd, e);
   endtask : rdchk

   // one sample, then room for the divider
   task automatic send(input logic [15:0] c, input logic [15:0] v, input logic [15:0] p);
      @(posedge pclk);
      go <= 1'b1;
      vals <= {c, v, p};
      @(posedge pclk);
      go <= 1'b0;
      repeat (44) @(posedge pclk);
   endtask : send

   task automatic pin(input int b, input logic l);
      @(posedge pclk);
      lvl[b] <= l;
      repeat (44) @(posedge pclk);
   endtask : pin

   task automatic t_reset();
      for (int g = 0; g < 3; g++) begin
         rdchk(8'(4 * g), 32'h0010_0000, "ctrl");
         rdchk(OFS_MIN0 + 8'(4 * g), 32'h0000_ffff, "min");
         rdchk(OFS_MAX0 + 8'(4 * g), 32'h0, "max");
      end
      apb(1'b0, 8'h60, 32'h0);
      chk("unmapped", {31'h0, er}, 32'h1);
      $display("reset test done");
   endtask : t_reset

   task automatic t_slide();
      logic [15:0] c [4] = '{16'd100, 16'd300, 16'd200, 16'd0};
      logic [15:0] e [4] = '{16'd100, 16'd200, 16'd200, 16'd150};
      for (int i = 0; i < 4; i++) begin
         send(c[i], c[i] / 10, c[i] * 2);
         rdchk(OFS_AVG0, 32'(e[i]), "cur avg");
         rdchk(OFS_AVG0 + 8'h04, 32'(e[i] / 10), "volt avg");
         rdchk(OFS_AVG0 + 8'h08, 32'(e[i] * 2), "pwr avg");
      end
      rdchk(OFS_PEAK0, 32'd200, "cur peak");
      rdchk(OFS_PEAK0 + 8'h08, 32'd400, "pwr peak");
      rdchk(OFS_MAX0, 32'd300, "cur max");
      $display("sliding test done");
   endtask : t_slide

   task automatic t_clear();
      apb(1'b1, OFS_CMD, 32'h7);
      repeat (3) @(posedge pclk);
      for (int g = 0; g < 3; g++) begin
         rdchk(OFS_AVG0 + 8'(4 * g), 32'h0, "avg cleared");
         rdchk(OFS_PEAK0 + 8'(4 * g), 32'h0, "peak cleared");
      end
      $display("command clear test done");
   endtask : t_clear

   task automatic t_fixed();
      apb(1'b1, 8'h04, 32'h0002_0001);
      send(16'd0, 16'd40, 16'd0);
      send(16'd0, 16'd60, 16'd0);
      rdchk(OFS_AVG0 + 8'h04, 32'd50, "fixed avg");
      send(16'd0, 16'd10, 16'd0);
      rdchk(OFS_AVG0 + 8'h04, 32'd50, "fixed hold");
      send(16'd0, 16'd30, 16'd0);
      rdchk(OFS_AVG0 + 8'h04, 32'd20, "fixed new");
      $display("fixed window test done");
   endtask : t_fixed

   task automatic t_edge();
      apb(1'b1, OFS_CTRL0, 32'h0010_0213);
      pin(1, 1'b1);
      send(16'd20, 16'd0, 16'd0);
      send(16'd40, 16'd0, 16'd0);
      pin(1, 1'b0);
      pin(1, 1'b1);
      rdchk(OFS_AVG0, 32'd30, "edge avg");
      pin(2, 1'b1);
      rdchk(OFS_AVG0, 32'h0, "pin clr avg");
      rdchk(OFS_PEAK0, 32'h0, "pin clr peak");
      send(16'd50, 16'd0, 16'd0);
      send(16'd70, 16'd0, 16'd0);
      pin(1, 1'b0);
      pin(1, 1'b1);
      rdchk(OFS_AVG0, 32'd60, "level kept");
      rdchk(OFS_PEAK0, 32'd60, "edge peak");
      pin(2, 1'b0);
      $display("edge test done");
   endtask : t_edge

   task automatic t_minmax();
      apb(1'b1, OFS_MMSEL, 32'h0000_0043);
      pin(3, 1'b1);
      rdchk(OFS_MIN0, 32'h0000_ffff, "min reset");
      rdchk(OFS_MAX0, 32'd300, "max kept");
      pin(4, 1'b1);
      rdchk(OFS_MAX0, 32'h0, "max reset");
      send(16'd5, 16'd5, 16'd5);
      rdchk(OFS_MIN0, 32'd5, "min new");
      rdchk(OFS_MAX0, 32'd5, "max new");
      $display("min max test done");
   endtask : t_minmax

   task automatic t_sledge();
      apb(1'b1, OFS_CTRL0 + 8'h08, 32'h0010_0052);
      send(16'd0, 16'd0, 16'd90);
      rdchk(OFS_AVG0 + 8'h08, 32'h0, "no first interval");
      pin(5, 1'b1);
      send(16'd0, 16'd0, 16'd10);
      rdchk(OFS_AVG0 + 8'h08, 32'd10, "edge slide one");
      send(16'd0, 16'd0, 16'd30);
      rdchk(OFS_AVG0 + 8'h08, 32'd20, "edge slide two");
      rdchk(OFS_PEAK0 + 8'h08, 32'd20, "pwr edge peak");
      $display("sliding edge test done");
   endtask : t_sledge

   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : results

   // main sequence
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_slide();
      t_clear();
      t_fixed();
      t_edge();
      t_minmax();
      t_sledge();
      results();
   end

   // watchdog
   initial begin
      repeat (20000) @(posedge pclk);
      err_total++;
      results();
   end
endmodule : tb_demand_average_calculator
`default_nettype wire
